// *** port_pin_config.sv ***
`timescale 1ns/1ns
// Summary of operation
// R1 - Input-kind bit per port 0 pin: 0 analog, 1 digital; resets to all ones.
// R2 - Analog pins lose pull-up, digital driver and digital receiver.
// R3 - Output-style bit per port 0 pin: 0 open-drain, 1 push-pull; resets zero.
// R4 - Skip bit set makes crossbar pass over the pin; resets to zero.
// R5 - Mask bit 0 excludes a port 1 pin from mismatch; resets to zero.
// R6 - Mask bit 1 compares the port 1 pin against its match bit.
// R7 - Match bit 0 compares against low, 1 against high; resets to ones.
// R8 - Mismatch event stays high while any compared pin differs from match.
module port_pin_config
  import portcfg_pkg::*;
(
  input  wire logic                  CLK_I,
  input  wire logic                  NRST_I,
  input  wire logic                  SFR_WR_I,
  input  wire logic                  SFR_RD_I,
  input  wire logic [7:0]            SFR_ADDR_I,
  input  wire logic [7:0]            SFR_WDATA_I,
  output logic      [7:0]            SFR_RDATA_O,
  output logic                       SFR_HIT_O,
  input  wire logic [PORT_WIDTH-1:0] PORT0_WEAK_PULLUP_I,
  input  wire logic [PORT_WIDTH-1:0] PORT0_DRIVE_REQ_I,
  input  wire logic [PORT_WIDTH-1:0] PORT1_PINS_I,
  output logic      [PORT_WIDTH-1:0] PORT0_PULLUP_EN_O,
  output logic      [PORT_WIDTH-1:0] PORT0_DRV_EN_O,
  output logic      [PORT_WIDTH-1:0] PORT0_RCV_EN_O,
  output logic      [PORT_WIDTH-1:0] PORT0_PUSH_PULL_O,
  output logic      [PORT_WIDTH-1:0] PORT0_SKIP_O,
  output logic                       PORT1_MISMATCH_O
);

  sfr_req_t  req;
  pad_ctrl_t pad_d;
  pad_ctrl_t pad_q;

  logic [7:0] input_kind_q;
  logic [7:0] output_style_q;
  logic [7:0] crossbar_skip_q;
  logic [7:0] compare_mask_q;
  logic [7:0] compare_value_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  logic hit_input_kind;
  logic hit_output_style;
  logic hit_crossbar_skip;
  logic hit_compare_mask;
  logic hit_compare_value;
  logic hit_any;
  logic strobe;

  logic wr_input_kind;
  logic wr_output_style;
  logic wr_crossbar_skip;
  logic wr_compare_mask;
  logic wr_compare_value;

  logic [7:0] input_kind_d;
  logic [7:0] output_style_d;
  logic [7:0] crossbar_skip_d;
  logic [7:0] compare_mask_d;
  logic [7:0] compare_value_d;
  logic [7:0] digital_pins;

  // One comparator per address so the write and read paths always agree
  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] reg_addr
  );
    return (addr == reg_addr);
  endfunction : addr_hit

  // A register keeps its value unless its own write enable is up
  function automatic logic [7:0] next_byte(
    input logic       we,
    input logic [7:0] cur,
    input logic [7:0] wdata
  );
    return we ? wdata : cur;
  endfunction : next_byte

  assign req = '{
    wr:    SFR_WR_I,
    rd:    SFR_RD_I,
    addr:  SFR_ADDR_I,
    wdata: SFR_WDATA_I
  };

  assign hit_input_kind    = addr_hit(req.addr, ADDR_PORT0_INPUT_KIND);
  assign hit_output_style  = addr_hit(req.addr, ADDR_PORT0_OUTPUT_STYLE);
  assign hit_crossbar_skip = addr_hit(req.addr, ADDR_PORT0_CROSSBAR_SKIP);
  assign hit_compare_mask  = addr_hit(req.addr, ADDR_PORT1_COMPARE_MASK);
  assign hit_compare_value = addr_hit(req.addr, ADDR_PORT1_COMPARE_VALUE);
  assign hit_any = hit_input_kind | hit_output_style | hit_crossbar_skip |
                   hit_compare_mask | hit_compare_value;
  assign strobe  = req.rd | req.wr;

  // The bus is shared with other registers, so a write needs strobe and exact address
  assign wr_input_kind    = req.wr & hit_input_kind;     // R1
  assign wr_output_style  = req.wr & hit_output_style;   // R3
  assign wr_crossbar_skip = req.wr & hit_crossbar_skip;  // R4
  assign wr_compare_mask  = req.wr & hit_compare_mask;   // R5 R6
  assign wr_compare_value = req.wr & hit_compare_value;  // R7

  assign input_kind_d    = next_byte(wr_input_kind, input_kind_q, req.wdata);
  assign output_style_d  = next_byte(wr_output_style, output_style_q, req.wdata);
  assign crossbar_skip_d = next_byte(wr_crossbar_skip, crossbar_skip_q, req.wdata);
  assign compare_mask_d  = next_byte(wr_compare_mask, compare_mask_q, req.wdata);
  assign compare_value_d = next_byte(wr_compare_value, compare_value_q, req.wdata);

  // Configuration registers load their next value on every clock
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      input_kind_q <= RST_PORT0_INPUT_KIND;  // R1
    end else begin
      input_kind_q <= input_kind_d;  // R1
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      output_style_q <= RST_PORT0_OUTPUT_STYLE;  // R3
    end else begin
      output_style_q <= output_style_d;  // R3
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      crossbar_skip_q <= RST_PORT0_CROSSBAR_SKIP;  // R4
    end else begin
      crossbar_skip_q <= crossbar_skip_d;  // R4
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      compare_mask_q <= RST_PORT1_COMPARE_MASK;  // R5
    end else begin
      compare_mask_q <= compare_mask_d;  // R6
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      compare_value_q <= RST_PORT1_COMPARE_VALUE;  // R7
    end else begin
      compare_value_q <= compare_value_d;  // R7
    end
  end

  // Read data is registered and holds its last value between reads
  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      if (hit_input_kind) begin
        rdata_d = input_kind_q;
      end else if (hit_output_style) begin
        rdata_d = output_style_q;
      end else if (hit_crossbar_skip) begin
        rdata_d = crossbar_skip_q;
      end else if (hit_compare_mask) begin
        rdata_d = compare_mask_q;
      end else if (hit_compare_value) begin
        rdata_d = compare_value_q;
      end else begin
        rdata_d = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_q <= UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Analog mode overrides pull-up, driver and receiver (not push-pull) so the pad never loads the analog node
  assign digital_pins    = input_kind_q;                        // R1
  assign pad_d.pullup_en = PORT0_WEAK_PULLUP_I & digital_pins;  // R2
  assign pad_d.drv_en    = PORT0_DRIVE_REQ_I & digital_pins;    // R2
  assign pad_d.rcv_en    = digital_pins;                        // R2
  assign pad_d.push_pull = output_style_q;                      // R3

  // Pad controls are registered so the pad ring sees glitch-free enables
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pad_q <= '{
        pullup_en: 8'h00,
        drv_en:    8'h00,
        rcv_en:    RST_PORT0_INPUT_KIND,
        push_pull: RST_PORT0_OUTPUT_STYLE
      };
    end else begin
      pad_q <= pad_d;
    end
  end

  // Pin sampling adds one cycle of latency to the mismatch event
  port1_mismatch #(
    .WIDTH (PORT_WIDTH)
  ) u_mismatch (
    .clk_i      (CLK_I),
    .nrst_i     (NRST_I),
    .pins_i     (PORT1_PINS_I),
    .mask_i     (compare_mask_q),
    .value_i    (compare_value_q),
    .mismatch_o (PORT1_MISMATCH_O)  // R8
  );

  assign SFR_RDATA_O       = rdata_q;
  assign SFR_HIT_O         = hit_any & strobe;
  assign PORT0_PULLUP_EN_O = pad_q.pullup_en;
  assign PORT0_DRV_EN_O    = pad_q.drv_en;
  assign PORT0_RCV_EN_O    = pad_q.rcv_en;
  assign PORT0_PUSH_PULL_O = pad_q.push_pull;
  assign PORT0_SKIP_O      = crossbar_skip_q;  // R4

endmodule : port_pin_config

// *** portcfg_pkg.sv ***
package portcfg_pkg;

  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned SFR_ADDR_WIDTH = 8;

  // Byte-wide special function register addresses
  localparam logic [7:0] ADDR_PORT0_OUTPUT_STYLE  = 8'ha4;
  localparam logic [7:0] ADDR_PORT0_CROSSBAR_SKIP = 8'hd4;
  localparam logic [7:0] ADDR_PORT1_COMPARE_VALUE = 8'hed;
  localparam logic [7:0] ADDR_PORT1_COMPARE_MASK  = 8'hee;
  localparam logic [7:0] ADDR_PORT0_INPUT_KIND    = 8'hf1;

  // Reset values
  localparam logic [7:0] RST_PORT0_INPUT_KIND    = 8'hff;
  localparam logic [7:0] RST_PORT0_OUTPUT_STYLE  = 8'h00;
  localparam logic [7:0] RST_PORT0_CROSSBAR_SKIP = 8'h00;
  localparam logic [7:0] RST_PORT1_COMPARE_MASK  = 8'h00;
  localparam logic [7:0] RST_PORT1_COMPARE_VALUE = 8'hff;

  // Value read back from an address this block does not own
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Core-side register access, one byte per cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Per-pin controls handed to the pad ring for port 0
  typedef struct packed {
    logic [7:0] pullup_en;
    logic [7:0] drv_en;
    logic [7:0] rcv_en;
    logic [7:0] push_pull;
  } pad_ctrl_t;

endpackage : portcfg_pkg

// *** port1_mismatch.sv ***
`timescale 1ns/1ns
module port1_mismatch
  import portcfg_pkg::*;
#(
  parameter int unsigned WIDTH = PORT_WIDTH
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] pins_i,
  input  wire logic [WIDTH-1:0] mask_i,
  input  wire logic [WIDTH-1:0] value_i,
  output logic                  mismatch_o
);

  logic [WIDTH-1:0] pins_q;
  logic [WIDTH-1:0] differ;

  // Pin levels are registered so the compare sees a stable sample
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_i;
    end
  end

  // Masked-off pins never contribute; compared pins are checked against their match bit
  assign differ     = (pins_q ^ value_i) & mask_i;  // R5 R6 R7
  assign mismatch_o = |differ;                      // R8

endmodule : port1_mismatch

// *** port_pin_config_sva.sv ***
`timescale 1ns/1ns
module port_pin_config_sva
  import portcfg_pkg::*;
(
  input wire logic       CLK_I,
  input wire logic       NRST_I,
  input wire logic       SFR_WR_I,
  input wire logic       SFR_RD_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic [7:0] PORT0_DRIVE_REQ_I,
  input wire logic [7:0] PORT1_PINS_I,
  input wire logic [7:0] PORT0_DRV_EN_O,
  input wire logic [7:0] PORT0_RCV_EN_O,
  input wire logic [7:0] PORT0_PUSH_PULL_O,
  input wire logic [7:0] PORT0_SKIP_O,
  input wire logic       PORT1_MISMATCH_O
);
  logic [7:0] mask_q;
  logic [7:0] val_q;
  wire w_kind = SFR_WR_I && SFR_ADDR_I == ADDR_PORT0_INPUT_KIND;
  wire w_style = SFR_WR_I && SFR_ADDR_I == ADDR_PORT0_OUTPUT_STYLE;
  wire w_skip = SFR_WR_I && SFR_ADDR_I == ADDR_PORT0_CROSSBAR_SKIP;
  wire w_mask = SFR_WR_I && SFR_ADDR_I == ADDR_PORT1_COMPARE_MASK;
  wire w_val = SFR_WR_I && SFR_ADDR_I == ADDR_PORT1_COMPARE_VALUE;
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mask_q <= RST_PORT1_COMPARE_MASK;
      val_q  <= RST_PORT1_COMPARE_VALUE;
    end else begin
      if (w_mask) mask_q <= SFR_WDATA_I;
      if (w_val) val_q <= SFR_WDATA_I;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  a_rcv_follows_kind: assert property (w_kind |-> ##2 PORT0_RCV_EN_O == $past(SFR_WDATA_I, 2))
    else $error("receiver enable missed input kind");
  a_drive_gated: assert property ($past(NRST_I) |->
    PORT0_DRV_EN_O == ($past(PORT0_DRIVE_REQ_I) & PORT0_RCV_EN_O))
    else $error("driver not gated by input kind");
  a_style_follows: assert property (w_style |-> ##2 PORT0_PUSH_PULL_O == $past(SFR_WDATA_I, 2))
    else $error("push-pull missed output style");
  a_skip_follows: assert property (w_skip |=> PORT0_SKIP_O == $past(SFR_WDATA_I))
    else $error("skip output missed write");
  a_mask_zero_quiet: assert property (mask_q == 8'h00 |-> !PORT1_MISMATCH_O)
    else $error("mismatch with empty mask");
  a_mismatch_level: assert property ($past(NRST_I) |->
    PORT1_MISMATCH_O == |(($past(PORT1_PINS_I) ^ val_q) & mask_q))
    else $error("mismatch level wrong");
  a_mask_readback: assert property (SFR_RD_I && SFR_ADDR_I == ADDR_PORT1_COMPARE_MASK |=>
    SFR_RDATA_O == $past(mask_q))
    else $error("mask read back wrong");
  a_mask_write_cause: assert property (w_mask && SFR_WDATA_I == 8'h00 |=> !PORT1_MISMATCH_O)
    else $error("mismatch after clearing mask");
  c_kind_write: cover property (w_kind);
  c_mismatch_seen: cover property (w_mask ##1 PORT1_MISMATCH_O);
  c_mismatch_gone: cover property (PORT1_MISMATCH_O ##1 !PORT1_MISMATCH_O);
endmodule : port_pin_config_sva
bind port_pin_config port_pin_config_sva port_pin_config_sva_inst (.*);

// *** pin_side_model.sv ***
`timescale 1ns/1ns
module pin_side_model (
  input  wire logic        clk_i,
  input  wire logic [23:0] want_i,
  output logic      [23:0] pins_o
);
  // Pads settle just after the edge, never on it
  initial pins_o = 24'h000000;
  always @(posedge clk_i) pins_o <= #1 want_i;
endmodule : pin_side_model

// *** test_port_pin_config.sv ***
`timescale 1ns/1ns
module test_port_pin_config
  import portcfg_pkg::*;
;
  logic CLK_I = 0, NRST_I = 0, wr = 0, rd = 0, mis, hit;
  logic [7:0] addr = 0, wd = 0, rdat, pull, drv, rcv, pp, skip;
  logic [23:0] want = 0, pins;
  int mismatches = 0, num_checks = 0, cyc = 0;
  initial forever #20 CLK_I = ~CLK_I;
  pin_side_model pin_side_model_inst (.clk_i(CLK_I), .want_i(want), .pins_o(pins));
  port_pin_config port_pin_config_inst (.CLK_I(CLK_I), .NRST_I(NRST_I), .SFR_WR_I(wr),
    .SFR_RD_I(rd), .SFR_ADDR_I(addr), .SFR_WDATA_I(wd), .SFR_RDATA_O(rdat), .SFR_HIT_O(hit),
    .PORT0_WEAK_PULLUP_I(pins[15:8]), .PORT0_DRIVE_REQ_I(pins[7:0]),
    .PORT1_PINS_I(pins[23:16]), .PORT0_PULLUP_EN_O(pull), .PORT0_DRV_EN_O(drv),
    .PORT0_RCV_EN_O(rcv), .PORT0_PUSH_PULL_O(pp), .PORT0_SKIP_O(skip),
    .PORT1_MISMATCH_O(mis));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask : tick
  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    wr = 1;
    addr = a;
    wd = d;
    tick(1);
    wr = 0;
  endtask : wrb
  task automatic rdb(input logic [7:0] a, input logic [7:0] e);
    tick(1);
    rd = 1;
    addr = a;
    #1;
    chk({7'h0, hit}, {7'h0, (a inside {ADDR_PORT0_INPUT_KIND, ADDR_PORT0_OUTPUT_STYLE,
      ADDR_PORT0_CROSSBAR_SKIP, ADDR_PORT1_COMPARE_MASK, ADDR_PORT1_COMPARE_VALUE})});
    tick(1);
    rd = 0;
    chk(rdat, e);
  endtask : rdb
  task give_verdict;
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    tick(5);
    NRST_I = 1;
    rdb(8'hf1, 8'hff);
    rdb(8'ha4, 8'h00);
    rdb(8'hd4, 8'h00);
    rdb(8'hee, 8'h00);
    rdb(8'hed, 8'hff);
    rdb(8'h55, UNMAPPED_READ);
    want = 24'h00ffff;
    tick(3);
    chk({7'h0, mis}, 8'h00);
    chk({7'h0, hit}, 8'h00);
    wrb(8'hf1, 8'h0f);
    tick(1);
    chk(rcv, 8'h0f);
    chk(pull, 8'h0f);
    chk(drv, 8'h0f);
    wrb(8'ha4, 8'h5a);
    tick(1);
    chk(pp, 8'h5a);
    rdb(8'ha4, 8'h5a);
    wrb(8'hd4, 8'h3c);
    chk(skip, 8'h3c);
    wrb(8'hee, 8'h01);
    chk({7'h0, mis}, 8'h01);
    wrb(8'hed, 8'hfe);
    chk({7'h0, mis}, 8'h00);
    want = 24'h01ffff;
    tick(2);
    chk({7'h0, mis}, 8'h01);
    tick(3);
    chk({7'h0, mis}, 8'h01);
    want = 24'h00ffff;
    tick(2);
    chk({7'h0, mis}, 8'h00);
    NRST_I = 0;
    tick(2);
    chk(pull, 8'h00);
    chk(drv, 8'h00);
    chk(rcv, 8'hff);
    chk(pp, 8'h00);
    chk(skip, 8'h00);
    chk(rdat, 8'h00);
    want = 24'h01ffff;
    NRST_I = 1;
    tick(2);
    chk(pull, 8'hff);
    chk({7'h0, mis}, 8'h00);
    rdb(8'hf1, 8'hff);
    rdb(8'hee, 8'h00);
    rdb(8'hed, 8'hff);
    rdb(8'ha4, 8'h00);
    rdb(8'hd4, 8'h00);
    give_verdict();
  end
endmodule : test_port_pin_config
